// ==== pkg/timer_pkg.sv ====
// Constants, register map and clock select codes of the dual timer/counter.
// Assumes a 32-bit APB slave port with byte addresses on a word grid.
package timer_pkg;

   // ****************************************************************
   // Bus and register map
   // ****************************************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_TIMER8_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_TIMER8_COUNT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_TIMER16_CONTROL_A = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_TIMER16_CONTROL_B = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_TIMER16_COUNT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_COMPARE_A = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_CAPTURE_VALUE = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_TIMER_IRQ_FLAGS = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_TIMER_IRQ_MASK = 8'h20;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRLA_PWM_BIT = 0;
   localparam int CTRLB_FILTER_BIT = 7;
   localparam int CTRLB_EDGE_BIT = 6;
   localparam int CTRLB_CTC_BIT = 3;
   localparam int FLAGS_W = 4;
   localparam int FLAG_OVF8 = 0;
   localparam int FLAG_OVF16 = 1;
   localparam int FLAG_CMPA = 2;
   localparam int FLAG_CAPT = 3;

   // ****************************************************************
   // Prescaler and filter counts
   // ****************************************************************
   localparam int PRE_W = 10;
   localparam int TAP8_BITS = 3;
   localparam int TAP64_BITS = 6;
   localparam int TAP256_BITS = 8;
   localparam int TAP1024_BITS = 10;
   localparam int FILTER_SAMPLES = 4;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [FLAGS_W-1:0] FLAGS_RESET = 4'h0;
   localparam logic [PRE_W-1:0] PRE_RESET = 10'h000;
   localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      CS_STOP,
      CS_CLK,
      CS_DIV8,
      CS_DIV64,
      CS_DIV256,
      CS_DIV1024,
      CS_EXT_FALL,
      CS_EXT_RISE
   } clk_sel_t;

endpackage : timer_pkg

// ==== rtl/dual_timer_counter_prescaler.sv ====
// Dual timer/counter: an 8-bit and a 16-bit counter on one 10-bit prescaler,
// with input capture, clear on compare A and an APB register port.
// Assumes pins arrive asynchronous to mclk and an APB3 master on mclk.
`timescale 1ns/1ps
`default_nettype none

module dual_timer_counter_prescaler #(
   parameter int T8_W = 8,
   parameter int T16_W = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [timer_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   // Pins
   input wire logic timer8_ext_input,
   input wire logic timer16_ext_input,
   input wire logic capture_input_pin,
   // Events towards the interrupt logic
   output logic [timer_pkg::FLAGS_W-1:0] timer_irq_request
);
   import timer_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [2:0] t8_sel;
      logic [T8_W-1:0] t8_cnt;
      logic pwm_en;
      logic filt_en;
      logic edge_sel;
      logic ctc_en;
      logic [2:0] t16_sel;
      logic [T16_W-1:0] t16_cnt;
      logic [T16_W-1:0] cmp_a;
      logic [T16_W-1:0] cap_val;
      logic [FLAGS_W-1:0] flags;
      logic [FLAGS_W-1:0] mask;
      logic [PRE_W-1:0] pre;
      logic e8_s1;
      logic e8_s2;
      logic e8_s3;
      logic e16_s1;
      logic e16_s2;
      logic e16_s3;
      logic cap_s1;
      logic [FILTER_SAMPLES:0] cap_hist;
      logic t16_moved;
      logic [FLAGS_W-1:0] irq_req;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_t;

   state_t st_reg;
   state_t st_next;

   logic xfer;
   logic wr_en;
   logic wr8cnt;
   logic wr16cnt;
   logic [3:0] taps;
   logic tick8;
   logic tick16;
   logic hit;
   logic reload;
   logic cap_trig;
   logic [FLAGS_W-1:0] set_vec;
   logic [FLAGS_W-1:0] clr_vec;

   // Tap choice shared by both counters; external edges come pre-synchronised
   function automatic logic pick_tick(input logic [2:0] sel, input logic [3:0] tp,
                                      input logic rise, input logic fall);
      logic t;
      t = 1'b0;
      unique case (clk_sel_t'(sel))
         CS_STOP: t = 1'b0;
         CS_CLK: t = 1'b1;
         CS_DIV8: t = tp[0];
         CS_DIV64: t = tp[1];
         CS_DIV256: t = tp[2];
         CS_DIV1024: t = tp[3];
         CS_EXT_FALL: t = fall;
         CS_EXT_RISE: t = rise;
      endcase
      return t;
   endfunction : pick_tick

   function automatic logic [31:0] read_mux(input state_t s, input logic [ADDR_W-1:0] a);
      logic [31:0] d;
      d = PRDATA_RESET;
      unique case (a)
         OFS_TIMER8_CONTROL: d[2:0] = s.t8_sel;
         OFS_TIMER8_COUNT: d[T8_W-1:0] = s.t8_cnt;
         OFS_TIMER16_CONTROL_A: d[CTRLA_PWM_BIT] = s.pwm_en;
         OFS_TIMER16_CONTROL_B:
         begin
            d[CTRLB_FILTER_BIT] = s.filt_en;
            d[CTRLB_EDGE_BIT] = s.edge_sel;
            d[CTRLB_CTC_BIT] = s.ctc_en;
            d[2:0] = s.t16_sel;
         end
         OFS_TIMER16_COUNT: d[T16_W-1:0] = s.t16_cnt;
         OFS_COMPARE_A: d[T16_W-1:0] = s.cmp_a;
         OFS_CAPTURE_VALUE: d[T16_W-1:0] = s.cap_val;
         OFS_TIMER_IRQ_FLAGS: d[FLAGS_W-1:0] = s.flags;
         OFS_TIMER_IRQ_MASK: d[FLAGS_W-1:0] = s.mask;
         default: d = PRDATA_RESET;
      endcase
      return d;
   endfunction : read_mux

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a == OFS_TIMER8_CONTROL) || (a == OFS_TIMER8_COUNT) ||
             (a == OFS_TIMER16_CONTROL_A) || (a == OFS_TIMER16_CONTROL_B) ||
             (a == OFS_TIMER16_COUNT) || (a == OFS_COMPARE_A) ||
             (a == OFS_CAPTURE_VALUE) || (a == OFS_TIMER_IRQ_FLAGS) ||
             (a == OFS_TIMER_IRQ_MASK);
   endfunction : is_mapped

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      st_next = st_reg;
      // One wait state: pready rises in the second access cycle
      xfer = psel & penable & st_reg.pready;
      wr_en = xfer & pwrite & is_mapped(paddr);
      wr8cnt = wr_en && (paddr == OFS_TIMER8_COUNT);
      wr16cnt = wr_en && (paddr == OFS_TIMER16_COUNT);
      st_next.pready = psel & penable & ~st_reg.pready;
      st_next.pslverr = psel & penable & ~st_reg.pready & ~is_mapped(paddr);
      st_next.prdata = (psel & penable & ~st_reg.pready & ~pwrite) ?
                       read_mux(st_reg, paddr) : PRDATA_RESET;

      // Prescaler runs free, so a tap's first tick after selection may come early
      st_next.pre = st_reg.pre + 1'b1;
      taps[0] = &st_reg.pre[TAP8_BITS-1:0];
      taps[1] = &st_reg.pre[TAP64_BITS-1:0];
      taps[2] = &st_reg.pre[TAP256_BITS-1:0];
      taps[3] = &st_reg.pre[TAP1024_BITS-1:0];

      // Pin synchronisers; the first flop feeds only the second
      st_next.e8_s1 = timer8_ext_input;
      st_next.e8_s2 = st_reg.e8_s1;
      st_next.e8_s3 = st_reg.e8_s2;
      st_next.e16_s1 = timer16_ext_input;
      st_next.e16_s2 = st_reg.e16_s1;
      st_next.e16_s3 = st_reg.e16_s2;
      st_next.cap_s1 = capture_input_pin;
      st_next.cap_hist = {st_reg.cap_hist[FILTER_SAMPLES-1:0], st_reg.cap_s1};

      tick8 = pick_tick(st_reg.t8_sel, taps, st_reg.e8_s2 & ~st_reg.e8_s3,
                        ~st_reg.e8_s2 & st_reg.e8_s3);
      tick16 = pick_tick(st_reg.t16_sel, taps, st_reg.e16_s2 & ~st_reg.e16_s3,
                         ~st_reg.e16_s2 & st_reg.e16_s3);

      set_vec = FLAGS_RESET;
      clr_vec = FLAGS_RESET;

      // 8-bit counter
      if (wr8cnt)
      begin
         st_next.t8_cnt = pwdata[T8_W-1:0];
      end
      else if (tick8)
      begin
         st_next.t8_cnt = st_reg.t8_cnt + 1'b1;
         set_vec[FLAG_OVF8] = &st_reg.t8_cnt;
      end

      // 16-bit counter; compare only counts after a real count step
      hit = st_reg.t16_moved && (st_reg.t16_cnt == st_reg.cmp_a);
      reload = hit && st_reg.ctc_en && !st_reg.pwm_en;
      set_vec[FLAG_CMPA] = hit;
      if (wr16cnt)
      begin
         st_next.t16_cnt = pwdata[T16_W-1:0];
      end
      else if (reload)
      begin
         st_next.t16_cnt = '0;
      end
      else if (tick16)
      begin
         st_next.t16_cnt = st_reg.t16_cnt + 1'b1;
         set_vec[FLAG_OVF16] = &st_reg.t16_cnt;
      end
      st_next.t16_moved = tick16 && !wr16cnt && !reload;

      // Capture: the filter costs three cycles of latency but rejects short glitches
      if (st_reg.filt_en)
      begin
         cap_trig = (st_reg.cap_hist[FILTER_SAMPLES-1:0] == {FILTER_SAMPLES{st_reg.edge_sel}})
                    && (st_reg.cap_hist[FILTER_SAMPLES] != st_reg.edge_sel);
      end
      else
      begin
         cap_trig = (st_reg.cap_hist[0] == st_reg.edge_sel) &&
                    (st_reg.cap_hist[1] != st_reg.edge_sel);
      end
      if (cap_trig)
      begin
         st_next.cap_val = st_reg.t16_cnt;
         set_vec[FLAG_CAPT] = 1'b1;
      end

      // Register writes
      if (wr_en)
      begin
         unique case (paddr)
            OFS_TIMER8_CONTROL: st_next.t8_sel = pwdata[2:0];
            OFS_TIMER16_CONTROL_A: st_next.pwm_en = pwdata[CTRLA_PWM_BIT];
            OFS_TIMER16_CONTROL_B:
            begin
               st_next.filt_en = pwdata[CTRLB_FILTER_BIT];
               st_next.edge_sel = pwdata[CTRLB_EDGE_BIT];
               st_next.ctc_en = pwdata[CTRLB_CTC_BIT];
               st_next.t16_sel = pwdata[2:0];
            end
            OFS_COMPARE_A: st_next.cmp_a = pwdata[T16_W-1:0];
            OFS_TIMER_IRQ_FLAGS: clr_vec = pwdata[FLAGS_W-1:0];
            OFS_TIMER_IRQ_MASK: st_next.mask = pwdata[FLAGS_W-1:0];
            default: st_next.mask = st_reg.mask;
         endcase
      end
      // A new event beats a write-one clear in the same cycle
      st_next.flags = (st_reg.flags & ~clr_vec) | set_vec;
      st_next.irq_req = st_next.flags & st_next.mask;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign prdata = st_reg.prdata;
   assign timer_irq_request = st_reg.irq_req;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   property p_ctc_reload;
      reload && !wr16cnt |=> st_reg.t16_cnt == '0 ##1
      (st_reg.t16_cnt <= T16_W'(1) || $past(wr16cnt));
   endproperty
   a_ctc_reload: assert property (p_ctc_reload) else $error("no reload after match A");

   property p_ctc_off;
      hit && (!st_reg.ctc_en || st_reg.pwm_en) && !wr16cnt |=>
      st_reg.t16_cnt == T16_W'($past(st_reg.t16_cnt) + $past(tick16));
   endproperty
   a_ctc_off: assert property (p_ctc_off) else $error("match moved count");

   property p_undivided_seq;
      st_reg.t16_sel == 3'h1 && st_reg.ctc_en && !st_reg.pwm_en && !wr_en &&
      st_reg.t16_moved && st_reg.t16_cnt == st_reg.cmp_a |=> st_reg.t16_cnt == '0;
   endproperty
   a_undivided_seq: assert property (p_undivided_seq) else $error("C not followed by 0");

   property p_ovf8;
      tick8 && !wr8cnt && &st_reg.t8_cnt |=> st_reg.t8_cnt == '0 && st_reg.flags[FLAG_OVF8];
   endproperty
   a_ovf8: assert property (p_ovf8) else $error("8-bit wrap without flag");

   property p_stop8;
      st_reg.t8_sel == 3'h0 && !wr8cnt |=> $stable(st_reg.t8_cnt);
   endproperty
   a_stop8: assert property (p_stop8) else $error("stopped counter moved");

   property p_taps;
      taps[3] |-> taps[2] && taps[1] && taps[0] && st_reg.pre == '1;
   endproperty
   a_taps: assert property (p_taps) else $error("tap nesting broken");

   property p_ext8;
      st_reg.t8_sel == 3'h7 && !wr8cnt && $rose(st_reg.e8_s2) |=>
      st_reg.t8_cnt == T8_W'($past(st_reg.t8_cnt) + 1'b1);
   endproperty
   a_ext8: assert property (p_ext8) else $error("external edge not counted");

   property p_write8;
      wr8cnt |=> st_reg.t8_cnt == $past(pwdata[T8_W-1:0]);
   endproperty
   a_write8: assert property (p_write8) else $error("count write lost");

   property p_capture;
      cap_trig |=> st_reg.cap_val == $past(st_reg.t16_cnt) && st_reg.flags[FLAG_CAPT];
   endproperty
   a_capture: assert property (p_capture) else $error("capture not taken");

   property p_filter;
      cap_trig && st_reg.filt_en |-> $past(st_reg.cap_hist[0], 3) == st_reg.edge_sel;
   endproperty
   a_filter: assert property (p_filter) else $error("filtered capture too early");

   property p_reserved;
      st_reg.pready && !pwrite && paddr == OFS_TIMER16_CONTROL_B |-> st_reg.prdata[5:4] == 2'b00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

   c_reload: cover property (reload);
   c_capture_filt: cover property (cap_trig && st_reg.filt_en);
   c_ovf8: cover property (set_vec[FLAG_OVF8]);
   c_set_beats_clear: cover property (|(set_vec & clr_vec));

endmodule : dual_timer_counter_prescaler

`default_nettype wire

// ==== verification/dual_timer_counter_prescaler_bench.sv ====
// Self-checking bench for the dual timer/counter: APB master tasks and pin pulsers.
// Assumes the design's own assertions sit inside the design files.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_prescaler_bench;
   import timer_pkg::*;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd, v, c;
   logic [2:0] pins;
   logic [FLAGS_W-1:0] irq;
   logic [31:0] seed = 32'h7da7_9d0d;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int w, n;

   dual_timer_counter_prescaler dual_timer_counter_prescaler_inst (
      .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .timer8_ext_input(pins[0]), .timer16_ext_input(pins[1]),
      .capture_input_pin(pins[2]), .timer_irq_request(irq));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xorshift

   function automatic int div_of(input int s);
      case (s)
         2: return 8;
         3: return 64;
         4: return 256;
         5: return 1024;
         default: return 1;
      endcase
   endfunction : div_of

   task automatic report_and_stop();
      if (num_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask : check

   task automatic check_range(input logic [31:0] got, input int lo, input int hi,
                              input string msg);
      n_tests++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         num_errors++;
         $display("mismatch at %0t: %s got %0d want %0d..%0d", $time, msg, got, lo, hi);
      end
   endtask : check_range

   // One APB transfer; entered just after a rising edge, leaves one idle cycle
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && k < 20)
      begin
         @(posedge mclk);
         k++;
      end
      if (k >= 20)
         check(32'h0, 32'h1, "no pready");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   // Pulses keep two clocks between pin transitions
   task automatic pulse(input int which, input int cnt);
      repeat (cnt)
      begin
         pins[which] <= 1'b1;
         repeat (2) @(posedge mclk);
         pins[which] <= 1'b0;
         repeat (2) @(posedge mclk);
      end
      repeat (4) @(posedge mclk);
   endtask : pulse

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         num_errors++;
         report_and_stop();
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, pins} = '0;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      apb(0, OFS_TIMER16_CONTROL_B, 0);
      check(rd, 32'h0, "control b reset");
      apb(0, OFS_TIMER8_COUNT, 0);
      check(rd, 32'h0, "count8 reset");
      apb(1, OFS_TIMER16_CONTROL_B, 32'h0000_00F8);
      apb(0, OFS_TIMER16_CONTROL_B, 0);
      check(rd, 32'h0000_00C8, "reserved bits");
      apb(1, OFS_TIMER16_CONTROL_B, 0);
      apb(0, 8'h24, 0);
      check({rd[30:0], err}, 32'h1, "unmapped read");
      // Every internal source on both counters; window of 16 ticks each
      for (int t = 0; t < 2; t++)
         for (int s = 1; s < 6; s++)
         begin
            w = 16 * div_of(s);
            apb(1, t ? OFS_TIMER16_COUNT : OFS_TIMER8_COUNT, 0);
            apb(1, t ? OFS_TIMER16_CONTROL_B : OFS_TIMER8_CONTROL, s);
            repeat (w) @(posedge mclk);
            apb(1, t ? OFS_TIMER16_CONTROL_B : OFS_TIMER8_CONTROL, 0);
            apb(0, t ? OFS_TIMER16_COUNT : OFS_TIMER8_COUNT, 0);
            check_range(rd, w / div_of(s), (w + 6) / div_of(s) + 1, "tap count");
         end
      // External pins, both edges, random start near the top to reach overflow
      apb(1, OFS_TIMER_IRQ_MASK, 32'h0000_000F);
      // Compare A out of reach, so a wrap through zero raises no match
      apb(1, OFS_COMPARE_A, 32'h0000_8000);
      for (int t = 0; t < 2; t++)
         for (int s = 6; s < 8; s++)
         begin
            v = t ? (32'h0000_FFF0 | (xorshift() & 32'hF)) : (32'hF0 | (xorshift() & 32'hF));
            n = 1 + (xorshift() & 32'hF);
            apb(1, OFS_TIMER_IRQ_FLAGS, 32'h0000_000F);
            apb(1, t ? OFS_TIMER16_COUNT : OFS_TIMER8_COUNT, v);
            apb(1, t ? OFS_TIMER16_CONTROL_B : OFS_TIMER8_CONTROL, s);
            pulse(t, n);
            apb(0, t ? OFS_TIMER16_COUNT : OFS_TIMER8_COUNT, 0);
            c = t ? 32'h0001_0000 : 32'h100;
            check(rd, (v + n) % c, "event count");
            check(32'(irq), 32'((v + n) >= c) << (t ? FLAG_OVF16 : FLAG_OVF8),
                  "overflow");
            apb(1, t ? OFS_TIMER16_CONTROL_B : OFS_TIMER8_CONTROL, 0);
         end
      apb(1, OFS_TIMER_IRQ_FLAGS, 32'h0000_000F);
      apb(0, OFS_TIMER_IRQ_FLAGS, 0);
      check({rd[27:0], irq}, 32'h0, "flags cleared");
      // Capture on each edge, with and without the filter
      for (int f = 0; f < 2; f++)
         for (int e = 0; e < 2; e++)
         begin
            pins[2] <= !e;
            repeat (8) @(posedge mclk);
            v = xorshift() & 32'hFFFF;
            apb(1, OFS_TIMER_IRQ_FLAGS, 32'h0000_000F);
            apb(1, OFS_TIMER16_COUNT, v);
            apb(1, OFS_TIMER16_CONTROL_B, (f << 7) | (e << 6));
            if (f)
            begin
               pins[2] <= e;
               repeat (2) @(posedge mclk);
               pins[2] <= !e;
               repeat (8) @(posedge mclk);
               check(32'(irq[FLAG_CAPT]), 32'h0, "filter let glitch through");
            end
            pins[2] <= e;
            repeat (10) @(posedge mclk);
            apb(0, OFS_CAPTURE_VALUE, 0);
            check(rd, v, "capture value");
            check(32'(irq[FLAG_CAPT]), 32'h1, "capture flag");
            apb(1, OFS_TIMER_IRQ_FLAGS, 32'h0000_000F);
            pins[2] <= !e;
            repeat (10) @(posedge mclk);
            check(32'(irq[FLAG_CAPT]), 32'h0, "wrong edge captured");
         end
      // Clear on compare A, then with the bit ignored and cleared
      c = 20 + (xorshift() & 32'hF);
      apb(1, OFS_TIMER16_COUNT, 0);
      apb(1, OFS_COMPARE_A, c);
      apb(1, OFS_TIMER16_CONTROL_B, 32'h0000_0009);
      repeat (8)
      begin
         apb(0, OFS_TIMER16_COUNT, 0);
         check_range(rd, 0, c, "count beyond compare");
      end
      check(32'(irq[FLAG_CMPA]), 32'h1, "compare flag");
      apb(1, OFS_TIMER16_CONTROL_A, 32'h0000_0001);
      repeat (40) @(posedge mclk);
      apb(0, OFS_TIMER16_COUNT, 0);
      check_range(rd, c + 1, 32'hFFFF, "pwm mode cleared");
      apb(1, OFS_TIMER16_CONTROL_A, 0);
      apb(1, OFS_TIMER16_CONTROL_B, 32'h0000_0001);
      apb(1, OFS_TIMER16_COUNT, 0);
      repeat (3 * c) @(posedge mclk);
      apb(0, OFS_TIMER16_COUNT, 0);
      check_range(rd, c + 1, 32'hFFFF, "cleared without bit");
      // Clear on compare under the divide by 8 tap
      apb(1, OFS_TIMER16_CONTROL_B, 32'h0000_000A);
      apb(1, OFS_TIMER16_COUNT, 0);
      repeat (20 * c) @(posedge mclk);
      apb(0, OFS_TIMER16_COUNT, 0);
      check_range(rd, 0, c, "divided clear on compare");
      report_and_stop();
   end
endmodule : dual_timer_counter_prescaler_bench
`default_nettype wire
